// ---- verilog/eesp_consts.svh ----
// Constants for the serial EEPROM pin interface
`ifndef EESP_CONSTS_SVH
`define EESP_CONSTS_SVH
`define EESP_CLK_HZ 40000000
`define EESP_MS_PER_S 1000
`define EESP_WRITE_TIME_MS 5
`define EESP_TIMER_W 24
`define EESP_ADDR_W 17
`define EESP_MEM_DEPTH 131072
`define EESP_PAGE_W 9
`define EESP_PAGE_BYTES 256
`define EESP_ADDR_LAST 2'h2
`define EESP_OP_WRSR 8'h01
`define EESP_OP_WRITE 8'h02
`define EESP_OP_READ 8'h03
`define EESP_OP_WRDI 8'h04
`define EESP_OP_RDSR 8'h05
`define EESP_OP_WREN 8'h06
`define EESP_SR_BUSY 0
`define EESP_SR_WEL 1
`define EESP_SR_BP_LO 2
`define EESP_SR_BP_HI 3
`define EESP_SR_GPE 7
`define EESP_SR_WMASK 8'h8C
`define EESP_BP_NONE 2'h0
`define EESP_BP_QUART 2'h1
`define EESP_BP_HALF 2'h2
`define EESP_QUART_TOP 2'h3
`define EESP_IN_W 5
`define EESP_IN_CS 0
`define EESP_IN_SCK 1
`define EESP_IN_SI 2
`define EESP_IN_GUARD 3
`define EESP_IN_PAUSE 4
`define EESP_BIT_LAST 3'h7
`define EESP_FIFO_DEPTH 2'h2
`endif

// ---- verilog/eesp_pkg.sv ----
// Types shared by the serial EEPROM pin interface
`include "eesp_consts.svh"
package eesp_pkg;
    typedef enum logic [1:0] {
        EK_START = 2'h0,
        EK_DATA = 2'h1,
        EK_END = 2'h2
    } eesp_kind_e;

    typedef struct packed {
        eesp_kind_e kind;
        logic partial;
        logic [7:0] data;
    } eesp_entry_s;

    typedef enum logic [8:0] {
        PH_IDLE = 9'h001,
        PH_OPC = 9'h002,
        PH_ADDR = 9'h004,
        PH_WDATA = 9'h008,
        PH_RDATA = 9'h010,
        PH_SROUT = 9'h020,
        PH_SRIN = 9'h040,
        PH_SKIP = 9'h080,
        PH_CHECK = 9'h100
    } eesp_phase_e;

    typedef struct packed {
        logic [`EESP_IN_W-1:0] sync1;
        logic [`EESP_IN_W-1:0] sync2;
        logic [`EESP_IN_W-1:0] prev;
        logic paused;
        logic [2:0] bitcnt;
        logic [7:0] rx_shift;
        logic [7:0] tx_shift;
        logic so;
        logic so_oe_n;
        eesp_entry_s [1:0] fifo;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
        eesp_phase_e phase;
        logic [7:0] opcode;
        logic [1:0] addr_cnt;
        logic [`EESP_ADDR_W-1:0] addr;
        logic [`EESP_PAGE_W-1:0] pg_base;
        logic [`EESP_PAGE_BYTES-1:0] pmask;
        logic pg_any;
        logic [7:0] status;
        logic [7:0] sr_pending;
        logic sr_seen;
        logic guard_abort;
        logic end_partial;
        logic commit_page;
        logic commit_status;
        logic [`EESP_TIMER_W-1:0] timer;
    } eesp_state_s;
endpackage

// ---- verilog/eesp_device.sv ----
// Serial EEPROM device: SPI pin logic, command core and memory array
//
// Contract
// - Clock modes 0 and 3 both work; sampling and shifting are identical.
// - Serial input bits are ignored while device select is high.
// - Serial output is released (not driven) while deselected.
// - Serial input is captured on each rising serial clock edge.
// - Serial output changes only after falling serial clock edges.
// - Write-guard pin high permits all normal reads and writes.
// - Guard pin low with guard-enable bit one refuses status writes.
// - Guard pin falling during a selected status write aborts it.
// - Once the self-timed cycle runs, the guard pin no longer matters.
// - Guard pin acts only when guard-enable is one; otherwise status writable.
// - Pause while selected suspends the sequence and keeps its progress.
// - While paused, input is ignored and output is released.
// - While paused, serial clock toggling does not advance the sequence.
// - The array holds 131072 addressable eight-bit locations.
// - The programming cycle is self-timed and ends within 5 ms.
// - Block protection of a quarter, half or all of the array blocks writes.
`timescale 1ns/100ps
`include "eesp_consts.svh"
module eesp_device #(
    parameter int unsigned WRITE_CYCLES =
        `EESP_WRITE_TIME_MS * (`EESP_CLK_HZ / `EESP_MS_PER_S)
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Serial pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_n_o,
    // Control pins
    input wire logic guard_n_i,
    input wire logic pause_n_i
);
    import eesp_pkg::*;

    localparam logic [`EESP_TIMER_W-1:0] TIMER_LAST = `EESP_TIMER_W'(WRITE_CYCLES - 1);
    localparam logic [`EESP_TIMER_W-1:0] COPY_END = `EESP_TIMER_W'(`EESP_PAGE_BYTES);

    eesp_state_s r;
    eesp_state_s n;

    logic [7:0] mem [0:`EESP_MEM_DEPTH-1];
    logic [7:0] pbuf [0:`EESP_PAGE_BYTES-1];

    logic mem_we;
    logic [`EESP_ADDR_W-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic pbuf_we;
    logic [7:0] pbuf_waddr;
    logic [7:0] pbuf_wdata;

    logic sel;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;
    logic push;
    logic fill_ready;
    logic core_ready;
    logic pop;
    logic busy;
    eesp_entry_s push_e;
    eesp_entry_s head;
    logic [7:0] tx_src;
    logic [7:0] copy_idx;

    // Protected region lies at the top of the array
    function automatic logic eesp_protected(input logic [1:0] bp,
                                            input logic [`EESP_PAGE_W-1:0] page);
        logic hit;
        hit = 1'b1;
        case (bp)
            `EESP_BP_NONE: hit = 1'b0;
            `EESP_BP_QUART: hit = (page[`EESP_PAGE_W-1 -: 2] == `EESP_QUART_TOP);
            `EESP_BP_HALF: hit = page[`EESP_PAGE_W-1];
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    always_comb
    begin
        n = r;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;
        pbuf_we = 1'b0;
        pbuf_waddr = r.addr[7:0];
        pbuf_wdata = '0;
        push = 1'b0;
        push_e = '0;
        copy_idx = r.timer[7:0];
        busy = r.status[`EESP_SR_BUSY];

        // Three flops on every pin; the first is never looked at, the last only for edges
        n.sync1 = {pause_n_i, guard_n_i, si_i, sclk_i, cs_n_i};
        n.sync2 = r.sync1;
        n.prev = r.sync2;
        si_bit = r.sync2[`EESP_IN_SI];

        sel = !r.sync2[`EESP_IN_CS];
        cs_fall = r.prev[`EESP_IN_CS] && !r.sync2[`EESP_IN_CS];
        cs_rise = !r.prev[`EESP_IN_CS] && r.sync2[`EESP_IN_CS];
        sck_rise = !r.prev[`EESP_IN_SCK] && r.sync2[`EESP_IN_SCK] && sel && !r.paused;
        sck_fall = r.prev[`EESP_IN_SCK] && !r.sync2[`EESP_IN_SCK] && sel && !r.paused;

        // Deselect clears pause state; while selected it only moves with the clock low, so no edge is half taken
        if (!sel)
        begin
            n.paused = 1'b0;
        end
        else if (!r.sync2[`EESP_IN_SCK])
        begin
            n.paused = !r.sync2[`EESP_IN_PAUSE];
        end

        // Output byte source, chosen by the command phase
        if (r.phase == PH_RDATA)
        begin
            tx_src = mem[r.addr];
        end
        else if (r.phase == PH_SROUT)
        begin
            tx_src = r.status;
        end
        else
        begin
            tx_src = 8'h00;
        end

        // Receive shifter and frame events
        if (cs_fall)
        begin
            n.bitcnt = 3'h0;
            push = 1'b1;
            push_e.kind = EK_START;
        end
        else if (cs_rise)
        begin
            push = 1'b1;
            push_e.kind = EK_END;
            push_e.partial = (r.bitcnt != 3'h0);
        end
        else if (sck_rise)
        begin
            n.rx_shift = {r.rx_shift[6:0], si_bit};
            n.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == `EESP_BIT_LAST)
            begin
                push = 1'b1;
                push_e.kind = EK_DATA;
                push_e.data = {r.rx_shift[6:0], si_bit};
            end
        end

        // A fall with the bit count at zero starts a new output byte; in mode 3
        // the fall right after select also lands here, harmlessly
        if (sck_fall)
        begin
            if (r.bitcnt == 3'h0)
            begin
                n.so = tx_src[7];
                n.tx_shift = {tx_src[6:0], 1'b0};
                if (r.phase == PH_RDATA)
                begin
                    n.addr = r.addr + `EESP_ADDR_W'(1);
                end
            end
            else
            begin
                n.so = r.tx_shift[7];
                n.tx_shift = {r.tx_shift[6:0], 1'b0};
            end
        end

        n.so_oe_n = !(sel && !r.paused &&
                      (r.phase == PH_RDATA || r.phase == PH_SROUT));

        // Two-entry buffer between the pin side and the command core
        fill_ready = (r.count != `EESP_FIFO_DEPTH);
        core_ready = (r.phase != PH_CHECK);
        pop = (r.count != 2'h0) && core_ready;
        head = r.fifo[r.rd_ptr];
        if (push && fill_ready)
        begin
            n.fifo[r.wr_ptr] = push_e;
            n.wr_ptr = !r.wr_ptr;
        end
        if (pop)
        begin
            n.rd_ptr = !r.rd_ptr;
        end
        n.count = r.count + {1'b0, push && fill_ready} - {1'b0, pop};

        // Command core
        if (pop && head.kind == EK_START)
        begin
            n.phase = PH_OPC;
            n.addr_cnt = 2'h0;
            n.sr_seen = 1'b0;
            n.guard_abort = 1'b0;
            n.pg_any = 1'b0;
            if (!busy)
            begin
                n.pmask = '0;
            end
        end
        else if (pop && head.kind == EK_END)
        begin
            n.phase = PH_CHECK;
            n.end_partial = head.partial;
        end
        else
        begin
            case (r.phase)
                PH_OPC:
                begin
                    if (pop)
                    begin
                        n.opcode = head.data;
                        n.phase = PH_SKIP;
                        if (head.data == `EESP_OP_RDSR)
                        begin
                            n.phase = PH_SROUT;
                        end
                        else if (busy)
                        begin
                            n.phase = PH_SKIP;
                        end
                        else if (head.data == `EESP_OP_READ)
                        begin
                            n.phase = PH_ADDR;
                        end
                        else if (head.data == `EESP_OP_WRITE && r.status[`EESP_SR_WEL])
                        begin
                            n.phase = PH_ADDR;
                        end
                        else if (head.data == `EESP_OP_WRSR && r.status[`EESP_SR_WEL])
                        begin
                            n.phase = PH_SRIN;
                        end
                        else if (head.data == `EESP_OP_WREN)
                        begin
                            n.status[`EESP_SR_WEL] = 1'b1;
                        end
                        else if (head.data == `EESP_OP_WRDI)
                        begin
                            n.status[`EESP_SR_WEL] = 1'b0;
                        end
                    end
                end
                PH_ADDR:
                begin
                    if (pop)
                    begin
                        // Upper address bits beyond the array are dropped
                        n.addr = {r.addr[`EESP_ADDR_W-9:0], head.data};
                        n.addr_cnt = r.addr_cnt + 2'h1;
                        if (r.addr_cnt == `EESP_ADDR_LAST)
                        begin
                            n.pg_base = r.addr[`EESP_ADDR_W-9:0];
                            n.phase = (r.opcode == `EESP_OP_READ) ? PH_RDATA : PH_WDATA;
                        end
                    end
                end
                PH_WDATA:
                begin
                    if (pop)
                    begin
                        // Offset wraps inside the page, later bytes overwrite earlier
                        pbuf_we = 1'b1;
                        pbuf_wdata = head.data;
                        n.pmask[r.addr[7:0]] = 1'b1;
                        n.addr[7:0] = r.addr[7:0] + 8'h01;
                        n.pg_any = 1'b1;
                    end
                end
                PH_SRIN:
                begin
                    if (pop && !r.sr_seen)
                    begin
                        n.sr_pending = head.data;
                        n.sr_seen = 1'b1;
                    end
                end
                PH_CHECK:
                begin
                    n.phase = PH_IDLE;
                    if (r.opcode == `EESP_OP_WRITE && r.pg_any && !r.end_partial &&
                        !eesp_protected(r.status[`EESP_SR_BP_HI:`EESP_SR_BP_LO], r.pg_base))
                    begin
                        n.commit_page = 1'b1;
                        n.status[`EESP_SR_BUSY] = 1'b1;
                        n.timer = '0;
                    end
                    else if (r.opcode == `EESP_OP_WRSR && r.sr_seen && !r.end_partial &&
                             !r.guard_abort &&
                             !(!r.sync2[`EESP_IN_GUARD] && r.status[`EESP_SR_GPE]))
                    begin
                        n.commit_status = 1'b1;
                        n.status[`EESP_SR_BUSY] = 1'b1;
                        n.timer = '0;
                    end
                end
                default:
                begin
                    n.phase = r.phase;
                end
            endcase
        end

        // Guard pin seen low during a selected status write spoils it
        if (sel && r.phase == PH_SRIN && !r.sync2[`EESP_IN_GUARD] && r.status[`EESP_SR_GPE])
        begin
            n.guard_abort = 1'b1;
        end

        // Self-timed cycle: page copied in the first 256 cycles, status at the end;
        // the guard pin is not looked at here at all
        if (busy)
        begin
            n.timer = r.timer + `EESP_TIMER_W'(1);
            if (r.commit_page && r.timer < COPY_END && r.pmask[copy_idx])
            begin
                mem_we = 1'b1;
                mem_waddr = {r.pg_base, copy_idx};
                mem_wdata = pbuf[copy_idx];
            end
            if (r.timer == TIMER_LAST)
            begin
                n.status[`EESP_SR_BUSY] = 1'b0;
                n.status[`EESP_SR_WEL] = 1'b0;
                n.commit_page = 1'b0;
                n.commit_status = 1'b0;
                if (r.commit_status)
                begin
                    n.status = (r.status & ~`EESP_SR_WMASK) |
                               (r.sr_pending & `EESP_SR_WMASK);
                    n.status[`EESP_SR_BUSY] = 1'b0;
                    n.status[`EESP_SR_WEL] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            r <= '0;
            r.sync1 <= '1;
            r.sync2 <= '1;
            r.prev <= '1;
            r.so_oe_n <= 1'b1;
            r.phase <= PH_IDLE;
        end
        else
        begin
            r <= n;
        end
    end

    // Array contents survive reset, as a non-volatile store would
    always_ff @(posedge clk_sys_i)
    begin
        if (mem_we)
        begin
            mem[mem_waddr] <= mem_wdata;
        end
        if (pbuf_we)
        begin
            pbuf[pbuf_waddr] <= pbuf_wdata;
        end
    end

    assign so_o = r.so;
    assign so_oe_n_o = r.so_oe_n;
endmodule

// ---- tb/eesp_device_properties.sv ----
// Port checks for the serial EEPROM pin logic
`timescale 1ns/100ps
module eesp_device_properties #(
    parameter int unsigned WRITE_CYCLES = 300
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    input wire logic guard_n_i,
    input wire logic pause_n_i
);
    logic sclk_reg;
    logic [3:0] age_reg;
    // Cycles since the clock pin fell; saturates so it cannot wrap
    always_ff @(posedge clk_sys_i)
    begin
        sclk_reg <= sclk_i;
        if (!rstn_i || (sclk_reg && !sclk_i))
        begin
            age_reg <= 4'h0;
        end
        else if (age_reg != 4'hF)
        begin
            age_reg <= age_reg + 4'h1;
        end
    end
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_idle;
        cs_n_i [*6];
    endsequence
    sequence s_paused;
        (!cs_n_i && !pause_n_i) [*8];
    endsequence
    sequence s_high;
        sclk_i [*6] ##0 !so_oe_n_o;
    endsequence
    chk_idle_release: assert property (s_idle |-> so_oe_n_o)
        else $error("output driven while idle");
    chk_pause_release: assert property (s_paused |-> so_oe_n_o)
        else $error("output driven while paused");
    chk_pause_frozen: assert property (s_paused |-> $stable(so_o))
        else $error("output moved while paused");
    chk_idle_frozen: assert property (cs_n_i [*4] |-> $stable(so_o))
        else $error("output moved while idle");
    chk_shift_on_fall: assert property ($changed(so_o) && !so_oe_n_o |-> age_reg <= 4'h6)
        else $error("output moved away from a clock fall");
    chk_steady_high: assert property (s_high |-> $stable(so_o))
        else $error("output moved while clock high");
    chk_drive_cause: assert property ($fell(so_oe_n_o) |-> !$past(cs_n_i, 3) && $past(pause_n_i, 2))
        else $error("output driven without select");
    chk_reset_quiet: assert property ($rose(rstn_i) |-> so_oe_n_o && !so_o)
        else $error("output driven after reset");
endmodule
bind eesp_device eesp_device_properties #(.WRITE_CYCLES(WRITE_CYCLES)) props (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .cs_n_i(cs_n_i),
    .sclk_i(sclk_i),
    .si_i(si_i),
    .so_o(so_o),
    .so_oe_n_o(so_oe_n_o),
    .guard_n_i(guard_n_i),
    .pause_n_i(pause_n_i)
);

// ---- tb/eesp_master_model.sv ----
// Host-side bus master model for the serial EEPROM pins
`timescale 1ns/100ps
module eesp_master_model (
    // Clock
    input wire logic clk_i,
    // Pins toward the device
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o,
    output logic guard_n_o,
    output logic pause_n_o,
    input wire logic so_i,
    input wire logic so_oe_n_i
);
    logic si_bit;
    logic hold_si;
    logic noise;
    logic mode3;
    logic so_line;
    // A released data line must not keep showing the last bit
    assign si_o = hold_si ? si_bit : noise;
    // A released output line reads back as the inverse of its last level
    assign so_line = so_oe_n_i ? !so_i : so_i;
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        guard_n_o = 1'b1;
        pause_n_o = 1'b1;
        si_bit = 1'b0;
        hold_si = 1'b0;
        noise = 1'b0;
        mode3 = 1'b0;
    end
    always @(negedge clk_i)
    begin
        noise <= ~noise;
    end
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Serial clock stands at its idle level outside frames
    task automatic open_frame(input logic m3);
        mode3 = m3;
        sclk_o = m3;
        ticks(4);
        cs_n_o = 1'b0;
        ticks(4);
    endtask
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        hold_si = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            sclk_o = 1'b0;
            si_bit = tx[i];
            ticks(4);
            sclk_o = 1'b1;
            ticks(4);
            rx[i] = so_line;
        end
    endtask
    task automatic close_frame();
        sclk_o = mode3;
        ticks(4);
        cs_n_o = 1'b1;
        hold_si = 1'b0;
        ticks(8);
    endtask
    // Pause between bytes; the clock is low whenever the pause pin moves
    task automatic pause_mid(input int toggles, output logic oe_n);
        sclk_o = 1'b0;
        ticks(4);
        hold_si = 1'b0;
        pause_n_o = 1'b0;
        ticks(4);
        repeat (toggles)
        begin
            sclk_o = 1'b1;
            ticks(4);
            sclk_o = 1'b0;
            ticks(4);
        end
        ticks(4);
        oe_n = so_oe_n_i;
        pause_n_o = 1'b1;
        ticks(4);
    endtask
endmodule

// ---- tb/test_spi_eeprom_pin_interface.sv ----
// Self-checking bench for the serial EEPROM pin logic
`timescale 1ns/100ps
`include "eesp_consts.svh"
`define CHECK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module test_spi_eeprom_pin_interface;
    logic clk = 1'b0;
    logic rstn;
    logic cs_n, sclk, si, so, so_oe_n, guard_n, pause_n;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    eesp_master_model pin (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
        .guard_n_o(guard_n), .pause_n_o(pause_n), .so_i(so), .so_oe_n_i(so_oe_n));
    eesp_device #(.WRITE_CYCLES(300)) dut (.clk_sys_i(clk), .rstn_i(rstn), .cs_n_i(cs_n),
        .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n), .guard_n_i(guard_n),
        .pause_n_i(pause_n));
    task automatic give_verdict();
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic op2(input logic [7:0] op, input logic [7:0] tx, output logic [7:0] rx);
        logic [7:0] r;
        pin.open_frame(1'b0);
        pin.xbyte(op, r);
        pin.xbyte(tx, rx);
        pin.close_frame();
    endtask
    task automatic wren();
        logic [7:0] r;
        pin.open_frame(1'b0);
        pin.xbyte(`EESP_OP_WREN, r);
        pin.close_frame();
    endtask
    task automatic addr_frame(input logic m3, input logic [7:0] op, input logic [16:0] a);
        logic [7:0] r;
        pin.open_frame(m3);
        pin.xbyte(op, r);
        pin.xbyte({7'h00, a[16]}, r);
        pin.xbyte(a[15:8], r);
        pin.xbyte(a[7:0], r);
    endtask
    task automatic write_mem(input logic [16:0] a, input logic [23:0] d, input int n);
        logic [7:0] r;
        wren();
        addr_frame(1'b0, `EESP_OP_WRITE, a);
        for (int i = 0; i < n; i++)
        begin
            pin.xbyte(d[23 - 8 * i -: 8], r);
        end
        pin.close_frame();
    endtask
    task automatic read_mem(input logic m3, input logic [16:0] a, output logic [15:0] d);
        addr_frame(m3, `EESP_OP_READ, a);
        pin.xbyte(8'h00, d[15:8]);
        pin.xbyte(8'h00, d[7:0]);
        pin.close_frame();
    endtask
    // Polling is bounded, so a started cycle that never ends shows up as a mismatch
    task automatic wait_ready(input logic started);
        logic [7:0] st;
        int polls;
        polls = 0;
        op2(`EESP_OP_RDSR, 8'h00, st);
        if (started) `CHECK(st[0], 1'b1)
        while (st[0] !== 1'b0 && polls < 8)
        begin
            op2(`EESP_OP_RDSR, 8'h00, st);
            polls++;
        end
        if (started) `CHECK(st[1:0], 2'h0)
    endtask
    task automatic t_idle();
        logic [7:0] st;
        `CHECK(so_oe_n, 1'b1)
        pin.xbyte(`EESP_OP_WREN, st);
        pin.close_frame();
        op2(`EESP_OP_RDSR, 8'h00, st);
        `CHECK(st, 8'h00)
    endtask
    task automatic t_data();
        logic [15:0] d;
        write_mem(17'h1FFFE, 24'hA55AC3, 3);
        wait_ready(1'b1);
        read_mem(1'b1, 17'h1FFFE, d);
        `CHECK(d, 16'hA55A)
        read_mem(1'b0, 17'h1FF00, d);
        `CHECK(d[15:8], 8'hC3)
    endtask
    task automatic t_pause();
        logic [7:0] b0;
        logic [7:0] b1;
        logic oe_n;
        addr_frame(1'b0, `EESP_OP_READ, 17'h1FFFE);
        pin.xbyte(8'h00, b0);
        pin.pause_mid(3, oe_n);
        pin.xbyte(8'h00, b1);
        pin.close_frame();
        `CHECK(oe_n, 1'b1)
        `CHECK({b0, b1}, 16'hA55A)
    endtask
    task automatic t_guard();
        logic [7:0] st;
        pin.guard_n_o = 1'b0;
        wren();
        op2(`EESP_OP_WRSR, 8'h80, st);
        wait_ready(1'b1);
        op2(`EESP_OP_RDSR, 8'h00, st);
        `CHECK(st, 8'h80)
        wren();
        op2(`EESP_OP_WRSR, 8'h00, st);
        op2(`EESP_OP_RDSR, 8'h00, st);
        `CHECK(st, 8'h82)
        pin.guard_n_o = 1'b1;
        pin.open_frame(1'b0);
        pin.xbyte(`EESP_OP_WRSR, st);
        pin.guard_n_o = 1'b0;
        pin.ticks(16);
        pin.guard_n_o = 1'b1;
        pin.xbyte(8'h84, st);
        pin.close_frame();
        op2(`EESP_OP_RDSR, 8'h00, st);
        `CHECK(st, 8'h82)
        op2(`EESP_OP_WRSR, 8'h84, st);
        pin.guard_n_o = 1'b0;
        wait_ready(1'b1);
        op2(`EESP_OP_RDSR, 8'h00, st);
        `CHECK(st, 8'h84)
        pin.guard_n_o = 1'b1;
    endtask
    // Top quarter is protected now; the low page must still take writes
    task automatic t_protect();
        logic [15:0] d;
        write_mem(17'h1FFFE, 24'h110000, 1);
        wait_ready(1'b0);
        read_mem(1'b0, 17'h1FFFE, d);
        `CHECK(d[15:8], 8'hA5)
        write_mem(17'h00100, 24'h3C0000, 1);
        wait_ready(1'b1);
        read_mem(1'b1, 17'h00100, d);
        `CHECK(d[15:8], 8'h3C)
    endtask
    // Half and then all of the array protected: writes there are dropped
    task automatic t_regions();
        logic [15:0] d;
        logic [7:0] st;
        write_mem(17'h10000, 24'h5C0000, 1);
        wait_ready(1'b1);
        wren();
        op2(`EESP_OP_WRSR, 8'h88, st);
        wait_ready(1'b1);
        write_mem(17'h10000, 24'h660000, 1);
        wait_ready(1'b0);
        read_mem(1'b0, 17'h10000, d);
        `CHECK(d[15:8], 8'h5C)
        wren();
        op2(`EESP_OP_WRSR, 8'h8C, st);
        wait_ready(1'b1);
        write_mem(17'h00100, 24'h770000, 1);
        wait_ready(1'b0);
        read_mem(1'b1, 17'h00100, d);
        `CHECK(d[15:8], 8'h3C)
    endtask
    initial
    begin
        rstn = 1'b0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_idle();
        t_data();
        t_pause();
        t_guard();
        t_protect();
        t_regions();
        give_verdict();
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_errors++;
            give_verdict();
        end
    end
endmodule
